// ===== inc/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// apb byte addresses
`define PSS_ADDR_CTRL 12'h000
`define PSS_ADDR_VOUT_CMD 12'h004
`define PSS_ADDR_STATUS 12'h008
`define PSS_ADDR_SETPOINT 12'h00c
`define PSS_ADDR_TIMING 12'h010

// control register fields
`define PSS_CTRL_RESTORE_BIT 0

// status register fields
`define PSS_STAT_STATE_LSB 0
`define PSS_STAT_READY_BIT 3
`define PSS_STAT_RAMP_BIT 4
`define PSS_STAT_AT_TARGET_BIT 5
`define PSS_STAT_NVM_BIT 6
`define PSS_STAT_RES_BIT 7

// timing register fields
`define PSS_TIM_DLY_LSB 0
`define PSS_TIM_RAMP_LSB 8

// timing figures
`define PSS_CLK_HZ 250000000
`define PSS_MS_PER_S 1000
`define PSS_MEMCHK_MS 15
`define PSS_INIT_MS 6

// pin level thresholds in millivolts
`define PSS_LOW_MAX_MV 12'h320
`define PSS_HIGH_MIN_MV 12'h7d0

// output target limits and resistor weights, 10 mv units
`define PSS_VOUT_MIN 10'h03c
`define PSS_VOUT_MAX 10'h226
`define PSS_COARSE_WEIGHT 10'h019

// strap tables, entry index = coarse_class * 3 + fine_class, entry 0 in the low bits
`define PSS_VOUT_TBL {10'h1f4, 10'h14a, 10'h0fa, 10'h0b4, 10'h096, 10'h078, 10'h064, \
  10'h050, 10'h03c}
`define PSS_DLY_TBL {8'hc8, 8'h64, 8'h32, 8'h14, 8'h0a, 8'h05, 8'h00, 8'h00, 8'h00}
`define PSS_RAMP_TBL {8'hc8, 8'h64, 8'h32, 8'h14, 8'h0a, 8'h05, 8'h02, 8'h01, 8'h00}
`define PSS_DLY_RSV_A 4'h1
`define PSS_DLY_RSV_B 4'h2
`define PSS_STRAP_COLS 4'h3

`endif

// ===== inc/pss_pkg.sv
package pss_pkg;

  // multi-mode pin connection class
  typedef enum logic [1:0] {
    PSS_PIN_LOW,
    PSS_PIN_OPEN,
    PSS_PIN_HIGH,
    PSS_PIN_RES
  } pss_pin_t;

  // sequencer states
  typedef enum logic [2:0] {
    PSS_S_MEMCHK,
    PSS_S_PINS,
    PSS_S_READY,
    PSS_S_DELAY,
    PSS_S_RAMP,
    PSS_S_ON
  } pss_state_t;

  // whole state of the sequencer
  typedef struct packed {
    pss_state_t st;
    logic [31:0] cnt;
    logic [31:0] acc;
    logic [31:0] dly_cyc;
    logic [31:0] ramp_cyc;
    logic [9:0] target;
    logic [9:0] setpoint;
    logic [7:0] dly_ms;
    logic [7:0] ramp_ms;
    logic res_mode;
    logic nvm_loaded;
    logic [31:0] prdata;
  } pss_regs_t;

endpackage

// ===== src/pss_pin_class.sv
`timescale 1ns/10ps
`include "pss_params.svh"

module pss_pin_class
  import pss_pkg::*;
#(
  parameter logic [11:0] LOW_MAX_MV = `PSS_LOW_MAX_MV,
  parameter logic [11:0] HIGH_MIN_MV = `PSS_HIGH_MIN_MV
) (
  input wire logic [11:0] level_mv,
  input wire logic floating,
  input wire logic res_fitted,
  output pss_pin_t pin_class
);

  // resistor beats open, open beats measured level
  always_comb begin
    if (res_fitted) begin
      pin_class = PSS_PIN_RES;
    end else if (floating) begin
      pin_class = PSS_PIN_OPEN; // see RULE15
    end else if (level_mv < LOW_MAX_MV) begin
      pin_class = PSS_PIN_LOW; // see RULE15
    end else if (level_mv > HIGH_MIN_MV) begin
      pin_class = PSS_PIN_HIGH; // see RULE15
    end else begin
      pin_class = PSS_PIN_OPEN; // undefined band read as open
    end
  end

endmodule

// ===== src/pss_seq.sv
// Operation
// RULE1: coarse and fine straps pick one of nine targets, 0.6 V to 5.0 V.
// RULE2: fitted resistors give any target 0.6 V to 5.5 V in 10 mV steps.
// RULE3: target equals 25 times coarse resistor index plus fine index, 10 mV units.
// RULE4: software may write a target in the same 0.6 V to 5.5 V range.
// RULE5: after power up spend about 15 ms checking memory, load stored values.
// RULE6: a restore command repeats the memory check and the configuration load.
// RULE7: after memory check, sample all multi-mode pins and load their settings.
// RULE8: during memory check and pin sampling, ignore enable and bus traffic.
// RULE9: after loading, become ready: accept bus commands and respond to enable.
// RULE10: pre-ramp delay starts at enable and comes from the two delay pins.
// RULE11: never ramp earlier than 6 ms after enable; longer settings wait fully.
// RULE12: after the delay, ramp monotonically to target over the selected ramp time.
// RULE13: delay and ramp come independently from separate pin pairs, standard values.
// RULE14: an external sync clock must be stable before enable is raised.
// RULE15: pins read low below 0.8 V, high above 2.0 V, open when unconnected.
// RULE16: delay pins give 0,5,10,20,50,100,200 ms; 0 and 5 still wait 6 ms.
// RULE17: ramp pins give 0 to 200 ms; zero ramp jumps as fast as possible.
// RULE18: ramp steps the setpoint from zero to target evenly across the ramp time.
// RULE19: decoded pin settings latch at sampling end, held until power up or restore.
`timescale 1ns/10ps
`include "pss_params.svh"

module pss_seq
  import pss_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `PSS_CLK_HZ / `PSS_MS_PER_S,
  parameter int unsigned MEMCHK_CYC = `PSS_MEMCHK_MS * (`PSS_CLK_HZ / `PSS_MS_PER_S),
  parameter int unsigned INIT_CYC = `PSS_INIT_MS * (`PSS_CLK_HZ / `PSS_MS_PER_S)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_in,
  input wire logic [11:0] voltage_fine_select_pin_mv,
  input wire logic voltage_fine_select_pin_open,
  input wire logic [11:0] voltage_coarse_select_pin_mv,
  input wire logic voltage_coarse_select_pin_open,
  input wire logic fine_set_resistor_fitted,
  input wire logic [4:0] fine_step_index,
  input wire logic coarse_set_resistor_fitted,
  input wire logic [4:0] coarse_step_index,
  input wire logic [11:0] delay_select_low_pin_mv,
  input wire logic delay_select_low_pin_open,
  input wire logic [11:0] delay_select_high_pin_mv,
  input wire logic delay_select_high_pin_open,
  input wire logic [11:0] ramp_select_low_pin_mv,
  input wire logic ramp_select_low_pin_open,
  input wire logic [11:0] ramp_select_high_pin_mv,
  input wire logic ramp_select_high_pin_open,
  input wire logic nvm_vout_valid,
  input wire logic [9:0] nvm_vout,
  output logic [9:0] ref_setpoint,
  output logic ramp_active,
  output logic config_ready,
  output logic at_target
);

  // strap lookup tables, entry 0 in the low bits
  localparam logic [8:0][9:0] VOUT_TBL = `PSS_VOUT_TBL;
  localparam logic [8:0][7:0] DLY_TBL = `PSS_DLY_TBL;
  localparam logic [8:0][7:0] RAMP_TBL = `PSS_RAMP_TBL;

  // timing counts widened to the counter width
  localparam logic [31:0] CYC_MS = 32'(CYC_PER_MS);
  localparam logic [31:0] MEMCHK = 32'(MEMCHK_CYC);
  localparam logic [31:0] INIT = 32'(INIT_CYC);

  // whole sequencer state and its next value
  pss_regs_t r_reg;
  pss_regs_t r_next;

  // connection class of each multi-mode pin
  pss_pin_t cls_vf;
  pss_pin_t cls_vc;
  pss_pin_t cls_dl;
  pss_pin_t cls_dh;
  pss_pin_t cls_sl;
  pss_pin_t cls_sh;

  // bus decode
  logic busy;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic restore;
  logic vout_ok;

  // pin decode
  logic [3:0] vsel;
  logic [3:0] dsel;
  logic [3:0] ssel;
  logic [9:0] pin_target;
  logic [9:0] res_sum;

  // sequencer arithmetic
  logic [31:0] dly_calc;
  logic [31:0] ramp_calc;
  logic [31:0] acc_sum;

  // one classifier per multi-mode pin
  pss_pin_class u_vf (
    .level_mv(voltage_fine_select_pin_mv),
    .floating(voltage_fine_select_pin_open),
    .res_fitted(fine_set_resistor_fitted),
    .pin_class(cls_vf)
  );
  pss_pin_class u_vc (
    .level_mv(voltage_coarse_select_pin_mv),
    .floating(voltage_coarse_select_pin_open),
    .res_fitted(coarse_set_resistor_fitted),
    .pin_class(cls_vc)
  );
  // delay and ramp pins are strap only, so no resistor is ever reported there
  pss_pin_class u_dl (
    .level_mv(delay_select_low_pin_mv),
    .floating(delay_select_low_pin_open),
    .res_fitted(1'b0),
    .pin_class(cls_dl)
  );
  pss_pin_class u_dh (
    .level_mv(delay_select_high_pin_mv),
    .floating(delay_select_high_pin_open),
    .res_fitted(1'b0),
    .pin_class(cls_dh)
  );
  pss_pin_class u_sl (
    .level_mv(ramp_select_low_pin_mv),
    .floating(ramp_select_low_pin_open),
    .res_fitted(1'b0),
    .pin_class(cls_sl)
  );
  pss_pin_class u_sh (
    .level_mv(ramp_select_high_pin_mv),
    .floating(ramp_select_high_pin_open),
    .res_fitted(1'b0),
    .pin_class(cls_sh)
  );

  // table index from a pin pair: high pin picks the row, low pin the column
  function automatic logic [3:0] pair_index(input pss_pin_t row, input pss_pin_t col);
    logic [1:0] rr;
    logic [1:0] cc;
    rr = (row == PSS_PIN_RES) ? 2'(PSS_PIN_OPEN) : 2'(row);
    cc = (col == PSS_PIN_RES) ? 2'(PSS_PIN_OPEN) : 2'(col);
    pair_index = 4'(rr * `PSS_STRAP_COLS) + {2'h0, cc};
  endfunction

  // keep a target inside the legal output range
  function automatic logic [9:0] clamp_vout(input logic [9:0] v);
    if (v < `PSS_VOUT_MIN) begin
      clamp_vout = `PSS_VOUT_MIN;
    end else if (v > `PSS_VOUT_MAX) begin
      clamp_vout = `PSS_VOUT_MAX;
    end else begin
      clamp_vout = v;
    end
  endfunction

  // pin decode of target, delay and ramp
  always_comb begin
    vsel = pair_index(cls_vc, cls_vf); // see RULE1
    dsel = pair_index(cls_dh, cls_dl); // see RULE13
    ssel = pair_index(cls_sh, cls_sl); // see RULE13
    res_sum = 10'(coarse_step_index * `PSS_COARSE_WEIGHT) + {5'h00, fine_step_index}; // see RULE3
    // fine grained target only when both voltage pins carry resistors
    if (cls_vc == PSS_PIN_RES && cls_vf == PSS_PIN_RES) begin
      pin_target = clamp_vout(res_sum); // see RULE2
    end else begin
      pin_target = VOUT_TBL[vsel]; // see RULE1
    end
  end

  // apb decode; no wait states
  always_comb begin
    busy = (r_reg.st == PSS_S_MEMCHK) || (r_reg.st == PSS_S_PINS);
    addr_ok = (paddr == `PSS_ADDR_CTRL) || (paddr == `PSS_ADDR_VOUT_CMD) ||
              (paddr == `PSS_ADDR_STATUS) || (paddr == `PSS_ADDR_SETPOINT) ||
              (paddr == `PSS_ADDR_TIMING);
    wr_en = psel && penable && pwrite && addr_ok && !busy; // see RULE8
    rd_setup = psel && !penable && !pwrite;
    restore = wr_en && (paddr == `PSS_ADDR_CTRL) && pwdata[`PSS_CTRL_RESTORE_BIT]; // see RULE6
    vout_ok = (pwdata[31:10] == 22'h0) && (pwdata[9:0] >= `PSS_VOUT_MIN) &&
              (pwdata[9:0] <= `PSS_VOUT_MAX); // see RULE4
    pready = 1'b1;
    pslverr = psel && penable && (!addr_ok || busy); // see RULE8
  end

  // sequencer and register file
  always_comb begin
    r_next = r_reg;
    // delay and ramp lengths in cycles, ramp accumulator sum
    dly_calc = 32'(r_reg.dly_ms * CYC_MS);
    ramp_calc = 32'(r_reg.ramp_ms * CYC_MS);
    acc_sum = r_reg.acc + {22'h000000, r_reg.target};

    // read data captured in the setup phase, stable through the access phase
    if (rd_setup) begin
      r_next.prdata = 32'h00000000;
      if (busy) begin
        r_next.prdata = 32'h00000000; // see RULE8
      end else begin
        case (paddr)
          `PSS_ADDR_VOUT_CMD: r_next.prdata[9:0] = r_reg.target;
          `PSS_ADDR_STATUS: begin
            r_next.prdata[`PSS_STAT_STATE_LSB +: 3] = r_reg.st;
            r_next.prdata[`PSS_STAT_READY_BIT] = 1'b1;
            r_next.prdata[`PSS_STAT_RAMP_BIT] = (r_reg.st == PSS_S_RAMP);
            r_next.prdata[`PSS_STAT_AT_TARGET_BIT] = (r_reg.st == PSS_S_ON) &&
                                                      (r_reg.setpoint == r_reg.target);
            r_next.prdata[`PSS_STAT_NVM_BIT] = r_reg.nvm_loaded;
            r_next.prdata[`PSS_STAT_RES_BIT] = r_reg.res_mode;
          end
          `PSS_ADDR_SETPOINT: r_next.prdata[9:0] = r_reg.setpoint;
          `PSS_ADDR_TIMING: begin
            r_next.prdata[`PSS_TIM_DLY_LSB +: 8] = r_reg.dly_ms;
            r_next.prdata[`PSS_TIM_RAMP_LSB +: 8] = r_reg.ramp_ms;
          end
          default: r_next.prdata = 32'h00000000;
        endcase
      end
    end

    // software target, accepted only inside the legal range
    if (wr_en && paddr == `PSS_ADDR_VOUT_CMD && vout_ok) begin
      r_next.target = pwdata[9:0]; // see RULE4
    end

    case (r_reg.st)
      // memory check: stored target found here wins over the pins
      PSS_S_MEMCHK: begin
        r_next.setpoint = 10'h000;
        if (r_reg.cnt >= MEMCHK - 32'h00000001) begin
          r_next.cnt = 32'h00000000;
          r_next.nvm_loaded = nvm_vout_valid; // see RULE5
          if (nvm_vout_valid) begin
            r_next.target = clamp_vout(nvm_vout); // see RULE5
          end
          r_next.st = PSS_S_PINS; // see RULE7
        end else begin
          r_next.cnt = r_reg.cnt + 32'h00000001; // see RULE5
        end
      end
      // one cycle of pin sampling; settings latched here and held
      PSS_S_PINS: begin
        if (!r_reg.nvm_loaded) begin
          r_next.target = pin_target; // see RULE7
        end
        r_next.res_mode = (cls_vc == PSS_PIN_RES) && (cls_vf == PSS_PIN_RES);
        if (dsel == `PSS_DLY_RSV_A || dsel == `PSS_DLY_RSV_B) begin
          r_next.dly_ms = 8'h00; // reserved pair treated as shortest delay
        end else begin
          r_next.dly_ms = DLY_TBL[dsel]; // see RULE16
        end
        r_next.ramp_ms = RAMP_TBL[ssel]; // see RULE17
        r_next.st = PSS_S_READY; // see RULE19
      end
      // ready: bus live, wait for enable
      PSS_S_READY: begin
        r_next.setpoint = 10'h000;
        if (enable_in) begin
          r_next.cnt = 32'h00000000; // see RULE10
          // short settings still wait out the internal start-up time
          if (dly_calc > INIT) begin
            r_next.dly_cyc = dly_calc; // see RULE16
          end else begin
            r_next.dly_cyc = INIT; // see RULE11
          end
          r_next.ramp_cyc = ramp_calc; // see RULE12
          r_next.st = PSS_S_DELAY; // see RULE9
        end
      end
      // pre-ramp delay counted from the enable edge
      PSS_S_DELAY: begin
        if (r_reg.cnt >= r_reg.dly_cyc - 32'h00000001) begin
          r_next.cnt = 32'h00000000;
          r_next.acc = 32'h00000000;
          r_next.st = PSS_S_RAMP; // see RULE11
        end else begin
          r_next.cnt = r_reg.cnt + 32'h00000001; // see RULE10
        end
      end
      // evenly spread single-step increments, never a step down
      PSS_S_RAMP: begin
        if (r_reg.ramp_cyc == 32'h00000000 || r_reg.setpoint >= r_reg.target) begin
          r_next.setpoint = r_reg.target; // see RULE17
          r_next.st = PSS_S_ON;
        end else if (acc_sum >= r_reg.ramp_cyc) begin
          r_next.acc = acc_sum - r_reg.ramp_cyc; // see RULE18
          r_next.setpoint = r_reg.setpoint + 10'h001; // see RULE12
        end else begin
          r_next.acc = acc_sum; // see RULE18
        end
      end
      // regulating: follow later target changes one step per cycle
      PSS_S_ON: begin
        if (r_reg.setpoint < r_reg.target) begin
          r_next.setpoint = r_reg.setpoint + 10'h001;
        end else if (r_reg.setpoint > r_reg.target) begin
          r_next.setpoint = r_reg.setpoint - 10'h001;
        end
      end
      default: r_next.st = PSS_S_MEMCHK;
    endcase

    // enable dropped: output off, back to ready
    if ((r_reg.st == PSS_S_DELAY || r_reg.st == PSS_S_RAMP || r_reg.st == PSS_S_ON) &&
        !enable_in) begin
      r_next.setpoint = 10'h000;
      r_next.st = PSS_S_READY; // see RULE9
    end

    // restore restarts the whole load sequence
    if (restore) begin
      r_next.cnt = 32'h00000000;
      r_next.setpoint = 10'h000;
      r_next.nvm_loaded = 1'b0;
      r_next.st = PSS_S_MEMCHK; // see RULE6
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign prdata = r_reg.prdata;
  assign ref_setpoint = r_reg.setpoint;
  assign ramp_active = (r_reg.st == PSS_S_RAMP);
  assign config_ready = !((r_reg.st == PSS_S_MEMCHK) || (r_reg.st == PSS_S_PINS));
  assign at_target = (r_reg.st == PSS_S_ON) && (r_reg.setpoint == r_reg.target);

endmodule

// ===== test/pss_seq_properties.sv
`timescale 1ns/10ps
module pss_seq_props #(
  parameter int unsigned INIT_CYC = 1500000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic enable_in,
  input wire logic [9:0] ref_setpoint,
  input wire logic ramp_active,
  input wire logic config_ready,
  input wire logic at_target
);
  logic [31:0] en_cnt;
  // counts edges for which enable has stayed high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_cnt <= 32'h0;
    end else begin
      en_cnt <= enable_in ? en_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_busy_bus_err: assert property (psel && penable && !config_ready |-> pslverr)
    else $error("bus access while busy not refused");
  a_busy_idle: assert property (!config_ready |-> !ramp_active && !at_target)
    else $error("output active while busy");
  a_min_delay: assert property ($rose(ramp_active) |-> en_cnt >= INIT_CYC)
    else $error("ramp began too soon after enable");
  a_ramp_needs_en: assert property ($rose(ramp_active) |-> $past(enable_in))
    else $error("ramp began without enable");
  a_ramp_mono_up: assert property (
    ramp_active && $past(ramp_active) |-> ref_setpoint >= $past(ref_setpoint))
    else $error("setpoint fell during ramp");
  a_start_zero: assert property ($rose(ramp_active) |-> ref_setpoint == 10'h000)
    else $error("ramp did not start from zero");
  a_ramp_done: assert property (
    $fell(ramp_active) && $past(enable_in) && config_ready |-> at_target)
    else $error("ramp ended short of target");
  a_off_clears: assert property (
    !enable_in |=> ref_setpoint == 10'h000 && !ramp_active && !at_target)
    else $error("output kept after enable fell");
  c_ramp: cover property ($rose(ramp_active));
  c_on: cover property ($rose(at_target));
  c_refused: cover property (psel && penable && pslverr);
endmodule

bind pss_seq pss_seq_props #(.INIT_CYC(INIT_CYC)) pss_seq_props_inst (.*);

// ===== test/pss_strap_model.sv
`timescale 1ns/10ps
module pss_strap_model (
  input wire logic [11:0] pin_cls,
  output logic [11:0] voltage_fine_select_pin_mv,
  output logic [11:0] voltage_coarse_select_pin_mv,
  output logic [11:0] delay_select_low_pin_mv,
  output logic [11:0] delay_select_high_pin_mv,
  output logic [11:0] ramp_select_low_pin_mv,
  output logic [11:0] ramp_select_high_pin_mv,
  output logic voltage_fine_select_pin_open,
  output logic voltage_coarse_select_pin_open,
  output logic delay_select_low_pin_open,
  output logic delay_select_high_pin_open,
  output logic ramp_select_low_pin_open,
  output logic ramp_select_high_pin_open
);
  // code 0 low, 1 open, 2 high; a floating pin sits mid-rail, never at a clean level
  function automatic logic [11:0] lvl(input logic [1:0] c);
    lvl = (c == 2'h0) ? 12'h190 : ((c == 2'h2) ? 12'h9c4 : 12'h5dc);
  endfunction
  // two code bits per pin: fine, coarse, delay low, delay high, ramp low, ramp high
  assign voltage_fine_select_pin_mv = lvl(pin_cls[1:0]);
  assign voltage_coarse_select_pin_mv = lvl(pin_cls[3:2]);
  assign delay_select_low_pin_mv = lvl(pin_cls[5:4]);
  assign delay_select_high_pin_mv = lvl(pin_cls[7:6]);
  assign ramp_select_low_pin_mv = lvl(pin_cls[9:8]);
  assign ramp_select_high_pin_mv = lvl(pin_cls[11:10]);
  // unconnected flags
  assign voltage_fine_select_pin_open = pin_cls[1:0] == 2'h1;
  assign voltage_coarse_select_pin_open = pin_cls[3:2] == 2'h1;
  assign delay_select_low_pin_open = pin_cls[5:4] == 2'h1;
  assign delay_select_high_pin_open = pin_cls[7:6] == 2'h1;
  assign ramp_select_low_pin_open = pin_cls[9:8] == 2'h1;
  assign ramp_select_high_pin_open = pin_cls[11:10] == 2'h1;
endmodule

// ===== test/tb_powerup_config_softstart_seq.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module tb_powerup_config_softstart_seq;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, enable_in, err;
  logic [11:0] paddr, pin_cls;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] voltage_fine_select_pin_mv, voltage_coarse_select_pin_mv;
  logic [11:0] delay_select_low_pin_mv, delay_select_high_pin_mv;
  logic [11:0] ramp_select_low_pin_mv, ramp_select_high_pin_mv;
  logic voltage_fine_select_pin_open, voltage_coarse_select_pin_open;
  logic delay_select_low_pin_open, delay_select_high_pin_open;
  logic ramp_select_low_pin_open, ramp_select_high_pin_open;
  logic fine_set_resistor_fitted, coarse_set_resistor_fitted, nvm_vout_valid;
  logic [4:0] fine_step_index, coarse_step_index;
  logic [9:0] nvm_vout, ref_setpoint;
  logic ramp_active, config_ready, at_target;
  int errors = 0;
  int n_checks = 0;

  pss_seq #(.CYC_PER_MS(4), .MEMCHK_CYC(20), .INIT_CYC(24)) pss_seq_inst (.*);
  pss_strap_model pss_strap_model_inst (.*);

  // 250 mhz bus clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 100 && config_ready !== 1'b1; i++) @(posedge pclk);
    `CHK(config_ready, 1'b1)
  endtask

  // restore command, then wait out the reload
  task automatic restore();
    apb(1'b1, 12'h000, 32'h1);
    @(posedge pclk);
    wait_ready();
  endtask

  task automatic t_busy();
    enable_in <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, 12'h004, 32'h0000_0100);
    `CHK(err, 1'b1)
    enable_in <= 1'b0;
    wait_ready();
    `CHK(ramp_active, 1'b0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[3:0], 4'ha)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[9:0], 10'h03c)
  endtask

  // all nine strap combinations on the voltage, delay and ramp pairs at once
  task automatic t_straps();
    logic [9:0] vt [9] = '{10'h03c, 10'h050, 10'h064, 10'h078, 10'h096, 10'h0b4,
      10'h0fa, 10'h14a, 10'h1f4};
    logic [15:0] tt [9] = '{16'h0000, 16'h0100, 16'h0200, 16'h0505, 16'h0a0a,
      16'h1414, 16'h3232, 16'h6464, 16'hc8c8};
    logic [1:0] r;
    logic [1:0] c;
    for (int k = 0; k < 9; k++) begin
      r = 2'(k / 3);
      c = 2'(k % 3);
      pin_cls <= {r, c, r, c, r, c};
      restore();
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[9:0], vt[k])
      apb(1'b0, 12'h010, 32'h0);
      `CHK(rd[15:0], tt[k])
    end
    pin_cls <= 12'h000;
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[9:0], 10'h1f4)
  endtask

  task automatic t_res();
    fine_set_resistor_fitted <= 1'b1;
    coarse_set_resistor_fitted <= 1'b1;
    coarse_step_index <= 5'h05;
    fine_step_index <= 5'h08;
    restore();
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[9:0], 10'h085)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[7], 1'b1)
    coarse_step_index <= 5'h16;
    fine_step_index <= 5'h00;
    restore();
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[9:0], 10'h226)
    fine_set_resistor_fitted <= 1'b0;
    coarse_set_resistor_fitted <= 1'b0;
  endtask

  task automatic t_nvm();
    nvm_vout_valid <= 1'b1;
    nvm_vout <= 10'h07b;
    restore();
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[9:0], 10'h07b)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[6], 1'b1)
    nvm_vout_valid <= 1'b0;
  endtask

  // range ends accepted, one past each end dropped, then an unmapped place
  task automatic t_vout();
    logic [9:0] wv [4] = '{10'h03c, 10'h226, 10'h227, 10'h03b};
    logic [9:0] ev [4] = '{10'h03c, 10'h226, 10'h226, 10'h226};
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h004, {22'h0, wv[k]});
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[9:0], ev[k])
    end
    apb(1'b0, 12'h014, 32'h0);
    `CHK(err, 1'b1)
  endtask

  // enable, then time the delay and the ramp in bus cycles
  task automatic t_seq(input logic [11:0] pc, input int dly, input int rmp,
    input logic [9:0] tgt);
    int n;
    pin_cls <= pc;
    restore();
    enable_in <= 1'b1; // bench clock has run since time zero
    n = 0;
    do begin @(posedge pclk); n++; end while (ramp_active !== 1'b1 && n < 2000);
    `CHK(n >= dly && n <= dly + 3, 1'b1)
    n = 0;
    do begin @(posedge pclk); n++; end while (at_target !== 1'b1 && n < 2000);
    `CHK(n >= rmp && n <= rmp + 3, 1'b1)
    `CHK(ref_setpoint, tgt)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[7:0], 8'h2d)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(rd[9:0], tgt)
    enable_in <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(ref_setpoint, 10'h000)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the roughly seven hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, enable_in, nvm_vout_valid, err} = 7'h0;
    {fine_set_resistor_fitted, coarse_set_resistor_fitted} = 2'h0;
    {paddr, pin_cls, pwdata} = 56'h0;
    {fine_step_index, coarse_step_index, nvm_vout} = 20'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_busy();
    t_straps();
    t_res();
    t_nvm();
    t_vout();
    t_seq(12'h660, 80, 80, 10'h03c);
    t_seq(12'h04a, 24, 0, 10'h1f4);
    tally_and_finish();
  end
endmodule
